// ---- include/pife_pkg.sv ----
// Constants shared by the peripheral interrupt flag and enable block.
package pife_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PIFE_OFF_FLAGS3 = 8'h00;
    localparam logic [7:0] PIFE_OFF_EN1 = 8'h04;
    localparam logic [7:0] PIFE_OFF_EN2 = 8'h08;
    localparam logic [7:0] PIFE_OFF_EN3 = 8'h0C;
    localparam logic [7:0] PIFE_OFF_RCTL = 8'h10;
    localparam logic [7:0] PIFE_OFF_GATE = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned PIFE_BIT_RX2 = 5;
    localparam int unsigned PIFE_BIT_TX2 = 4;
    localparam int unsigned PIFE_BIT_TMR4 = 3;
    localparam int unsigned PIFE_BIT_PRIO = 7;
    localparam int unsigned PIFE_BIT_GATE = 0;
    localparam int unsigned PIFE_NUM_CC = 3;
    localparam int unsigned PIFE_NUM_SW_FLAGS = 4;
    localparam int unsigned PIFE_NUM_FLAGS3 = 6;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] PIFE_RST_EN = 8'h00;
    localparam logic [5:0] PIFE_RST_EN3 = 6'h00;
    localparam logic [3:0] PIFE_RST_FLAGS = 4'h0;
    localparam logic PIFE_RST_BIT = 1'b0;
    localparam logic [31:0] PIFE_RST_DATA = 32'h00000000;

    // Byte address match against one register offset.
    function automatic logic pife_hit(input logic [7:0] adr,
                                      input logic [7:0] off);
        pife_hit = (adr[7:2] == off[7:2]);
    endfunction : pife_hit

endpackage : pife_pkg

// ---- include/pife_flag_if.sv ----
// Link between the bus logic and the software clearable flag holder.
`timescale 1ns/1ps
`default_nettype none

interface pife_flag_if;
    logic wr;
    logic [3:0] wdata;
    logic [3:0] flags;

    modport owner (input wr, input wdata, output flags);
    modport user (output wr, output wdata, input flags);
endinterface : pife_flag_if

`default_nettype wire

// ---- design/pife_flags.sv ----
// Sticky timer and capture/compare flags of the third flag register.
`timescale 1ns/1ps
`default_nettype none

module pife_flags
    import pife_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic timer4_overflow_i,
    input wire logic [2:0] capcomp_event_i,
    input wire logic [2:0] capcomp_pwm_i,
    pife_flag_if.owner fl
);

    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [3:0] set_w;
    logic [3:0] wmask_w;

    assign fl.flags = flags_q;

    // ------------------------------------------------------------------
    // Next flag values
    // ------------------------------------------------------------------
    always_comb
    begin
        // A unit in pulse-width mode neither sets nor accepts its flag.
        set_w = {timer4_overflow_i, capcomp_event_i & ~capcomp_pwm_i};
        wmask_w = {1'b1, ~capcomp_pwm_i};
        flags_d = flags_q;
        if (fl.wr)
        begin
            flags_d = (flags_q & ~wmask_w) | (fl.wdata & wmask_w);
        end
        // Hardware set wins over a software clear in the same cycle.
        flags_d = flags_d | set_w;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_q <= PIFE_RST_FLAGS;
        else
            flags_q <= flags_d;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_pwm_never_sets;
        @(posedge clk_i) disable iff (rst_i)
        1 |=> ((($past(capcomp_pwm_i) & ~$past(flags_q[2:0]))
                & flags_q[2:0]) == 3'b000);
    endproperty
    a_pwm_never_sets: assert property (p_pwm_never_sets)
        else $error("Capture/compare flag set in PWM mode.");

    property p_event_sets;
        @(posedge clk_i) disable iff (rst_i)
        |(capcomp_event_i & ~capcomp_pwm_i) |=>
            ((flags_q[2:0] & $past(capcomp_event_i) & ~$past(capcomp_pwm_i))
             == ($past(capcomp_event_i) & ~$past(capcomp_pwm_i)));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("Capture or compare event did not set its flag.");

    property p_sticky;
        @(posedge clk_i) disable iff (rst_i)
        (flags_q != 4'h0) && !fl.wr |=> ((flags_q & $past(flags_q))
                                        == $past(flags_q));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Flag cleared without a software write.");

endmodule : pife_flags

`default_nettype wire

// ---- design/pife_top.sv ----
// Peripheral interrupt flags, enables and global gate on a Wishbone bus.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module pife_top
    import pife_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] periph_one_req_i,
    input wire logic [7:0] periph_two_req_i,
    input wire logic rx2_holds_data_i,
    input wire logic tx2_buf_empty_i,
    input wire logic timer4_overflow_i,
    input wire logic [2:0] capcomp_event_i,
    input wire logic [2:0] capcomp_pwm_i,
    output logic peripheral_irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] en1_q;
    logic [7:0] en1_d;
    logic [7:0] en2_q;
    logic [7:0] en2_d;
    logic [5:0] en3_q;
    logic [5:0] en3_d;
    logic prio_q;
    logic prio_d;
    logic gate_q;
    logic gate_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic irq_q;
    logic irq_d;
    logic rx2_q;
    logic tx2_q;
    logic wr_fire;
    logic [7:0] flags3_w;
    logic any_enabled;

    pife_flag_if fl ();

    pife_flags u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .timer4_overflow_i(timer4_overflow_i),
        .capcomp_event_i(capcomp_event_i),
        .capcomp_pwm_i(capcomp_pwm_i),
        .fl(fl)
    );

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign peripheral_irq_o = irq_q;

    // ------------------------------------------------------------------
    // Bus write strobe
    // ------------------------------------------------------------------
    // Writes land at the edge where the master samples the acknowledge.
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign fl.wr = wr_fire && pife_hit(wb_adr_i, PIFE_OFF_FLAGS3);
    assign fl.wdata = wb_dat_i[3:0];

    // Top bits are tied low, so nothing can be stored there.
    assign flags3_w = {2'b00, rx2_q, tx2_q, fl.flags};

    // ------------------------------------------------------------------
    // Request combining
    // ------------------------------------------------------------------
    always_comb
    begin
        any_enabled = (|(flags3_w[5:0] & en3_q))
                      | (|(periph_one_req_i & en1_q))
                      | (|(periph_two_req_i & en2_q));
        // Without the priority scheme the global gate must be open.
        irq_d = any_enabled && (prio_q || gate_q);
    end

    // ------------------------------------------------------------------
    // Register file and bus answer
    // ------------------------------------------------------------------
    always_comb
    begin
        en1_d = en1_q;
        en2_d = en2_q;
        en3_d = en3_q;
        prio_d = prio_q;
        gate_d = gate_q;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        dat_d = dat_q;
        if (wr_fire)
        begin
            if (pife_hit(wb_adr_i, PIFE_OFF_EN1))
                en1_d = wb_dat_i[7:0];
            if (pife_hit(wb_adr_i, PIFE_OFF_EN2))
                en2_d = wb_dat_i[7:0];
            if (pife_hit(wb_adr_i, PIFE_OFF_EN3))
                en3_d = wb_dat_i[5:0];
            if (pife_hit(wb_adr_i, PIFE_OFF_RCTL))
                prio_d = wb_dat_i[PIFE_BIT_PRIO];
            if (pife_hit(wb_adr_i, PIFE_OFF_GATE))
                gate_d = wb_dat_i[PIFE_BIT_GATE];
        end
        if (ack_d)
        begin
            // Unmapped offsets answer with zero and drop writes.
            dat_d = PIFE_RST_DATA;
            if (pife_hit(wb_adr_i, PIFE_OFF_FLAGS3))
                dat_d[7:0] = flags3_w;
            else if (pife_hit(wb_adr_i, PIFE_OFF_EN1))
                dat_d[7:0] = en1_q;
            else if (pife_hit(wb_adr_i, PIFE_OFF_EN2))
                dat_d[7:0] = en2_q;
            else if (pife_hit(wb_adr_i, PIFE_OFF_EN3))
                dat_d[5:0] = en3_q;
            else if (pife_hit(wb_adr_i, PIFE_OFF_RCTL))
                dat_d[PIFE_BIT_PRIO] = prio_q;
            else if (pife_hit(wb_adr_i, PIFE_OFF_GATE))
                dat_d[PIFE_BIT_GATE] = gate_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en1_q <= PIFE_RST_EN;
            en2_q <= PIFE_RST_EN;
            en3_q <= PIFE_RST_EN3;
            prio_q <= PIFE_RST_BIT;
            gate_q <= PIFE_RST_BIT;
            ack_q <= PIFE_RST_BIT;
            dat_q <= PIFE_RST_DATA;
            irq_q <= PIFE_RST_BIT;
            rx2_q <= PIFE_RST_BIT;
            tx2_q <= PIFE_RST_BIT;
        end
        else
        begin
            en1_q <= en1_d;
            en2_q <= en2_d;
            en3_q <= en3_d;
            prio_q <= prio_d;
            gate_q <= gate_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            irq_q <= irq_d;
            // Read-only mirrors; the serial port clears its own state.
            rx2_q <= rx2_holds_data_i;
            tx2_q <= tx2_buf_empty_i;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_unimpl_zero;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q
            && pife_hit(wb_adr_i, PIFE_OFF_FLAGS3)
            |=> wb_ack_o && (wb_dat_o[31:6] == 26'h0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("Unimplemented flag bits read nonzero.");

    property p_need_enable;
        @(posedge clk_i) disable iff (rst_i)
        $rose(peripheral_irq_o) |-> $past(any_enabled);
    endproperty
    a_need_enable: assert property (p_need_enable)
        else $error("Request raised with no enabled source.");

    property p_enable_raises;
        @(posedge clk_i) disable iff (rst_i)
        any_enabled && prio_q |=> peripheral_irq_o;
    endproperty
    a_enable_raises: assert property (p_enable_raises)
        else $error("Enabled source did not raise the request.");

    property p_en2_stores;
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && pife_hit(wb_adr_i, PIFE_OFF_EN2)
            |=> en2_q == $past(wb_dat_i[7:0]);
    endproperty
    a_en2_stores: assert property (p_en2_stores)
        else $error("Second enable register did not take the write.");

    property p_gate_blocks;
        @(posedge clk_i) disable iff (rst_i)
        !prio_q && !gate_q |=> !peripheral_irq_o;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("Request passed a closed global gate.");

    property p_serial_mirror;
        @(posedge clk_i) disable iff (rst_i)
        1 |=> (rx2_q == $past(rx2_holds_data_i))
              && (tx2_q == $past(tx2_buf_empty_i));
    endproperty
    a_serial_mirror: assert property (p_serial_mirror)
        else $error("Serial-two flag does not follow its buffer.");

    property p_serial_ro;
        @(posedge clk_i) disable iff (rst_i)
        fl.wr && (rx2_holds_data_i == rx2_q) |=> rx2_q == $past(rx2_q);
    endproperty
    a_serial_ro: assert property (p_serial_ro)
        else $error("Software write changed the receive flag.");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("Acknowledge held longer than one cycle.");

    property p_ack_follows;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("Request was not acknowledged in the next cycle.");

    property p_ack_needs_req;
        @(posedge clk_i) disable iff (rst_i)
        $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
    endproperty
    a_ack_needs_req: assert property (p_ack_needs_req)
        else $error("Acknowledge given without a request.");

    property p_en1_stores;
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && pife_hit(wb_adr_i, PIFE_OFF_EN1)
            |=> en1_q == $past(wb_dat_i[7:0]);
    endproperty
    a_en1_stores: assert property (p_en1_stores)
        else $error("First enable register did not take the write.");

    property p_en3_stores;
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && pife_hit(wb_adr_i, PIFE_OFF_EN3)
            |=> en3_q == $past(wb_dat_i[5:0]);
    endproperty
    a_en3_stores: assert property (p_en3_stores)
        else $error("Third enable register did not take the write.");

    property p_prio_stores;
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && pife_hit(wb_adr_i, PIFE_OFF_RCTL)
            |=> prio_q == $past(wb_dat_i[PIFE_BIT_PRIO]);
    endproperty
    a_prio_stores: assert property (p_prio_stores)
        else $error("Priority scheme bit did not take the write.");

    property p_gate_stores;
        @(posedge clk_i) disable iff (rst_i)
        wr_fire && pife_hit(wb_adr_i, PIFE_OFF_GATE)
            |=> gate_q == $past(wb_dat_i[PIFE_BIT_GATE]);
    endproperty
    a_gate_stores: assert property (p_gate_stores)
        else $error("Global gate bit did not take the write.");

    property p_gate_opens;
        @(posedge clk_i) disable iff (rst_i)
        any_enabled && gate_q |=> peripheral_irq_o;
    endproperty
    a_gate_opens: assert property (p_gate_opens)
        else $error("Open global gate did not pass an enabled source.");

    property p_masked_quiet;
        @(posedge clk_i) disable iff (rst_i)
        !any_enabled |=> !peripheral_irq_o;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("Request raised while every source was masked.");

    property p_flags3_read;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q
            && pife_hit(wb_adr_i, PIFE_OFF_FLAGS3)
            |=> wb_dat_o[7:0] == $past(flags3_w);
    endproperty
    a_flags3_read: assert property (p_flags3_read)
        else $error("Flag register read did not return the flag state.");

endmodule : pife_top

`default_nettype wire

// ---- sim/pife_src_model.sv ----
// Model of the peripheral event sources that feed the interrupt block.
`timescale 1ns/1ps
`default_nettype none

module pife_src_model (
    input wire logic clk_i,
    output logic [7:0] one_req_o,
    output logic [7:0] two_req_o,
    output logic rx2_o,
    output logic tx2_o,
    output logic tmr4_o,
    output logic [2:0] cc_ev_o,
    output logic [2:0] cc_pwm_o
);
    initial
    begin
        one_req_o = 8'h00;
        two_req_o = 8'h00;
        {rx2_o, tx2_o, tmr4_o} = 3'h0;
        cc_ev_o = 3'h0;
        cc_pwm_o = 3'h0;
    end

    // Request, buffer and mode levels change just after a clock edge.
    task automatic levels(input logic [7:0] one, input logic [7:0] two,
                          input logic [1:0] buf_st, input logic [2:0] pwm);
        @(posedge clk_i);
        one_req_o <= one;
        two_req_o <= two;
        {rx2_o, tx2_o} <= buf_st;
        cc_pwm_o <= pwm;
    endtask : levels

    // Capture, compare match or overflow lasts exactly one cycle.
    task automatic pulse(input logic tmr, input logic [2:0] cc);
        @(posedge clk_i);
        tmr4_o <= tmr;
        cc_ev_o <= cc;
        @(posedge clk_i);
        tmr4_o <= 1'h0;
        cc_ev_o <= 3'h0;
    endtask : pulse
endmodule : pife_src_model

`default_nettype wire

// ---- sim/pife_top_tb.sv ----
// Self-checking bench for the peripheral interrupt flag and enable block.
`timescale 1ns/1ps
`default_nettype none

module pife_top_tb
    import pife_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, rx2, tx2, tmr4;
    logic [7:0] one_req, two_req;
    logic [2:0] cc_ev, cc_pwm;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};

    pife_top pife_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .periph_one_req_i(one_req),
        .periph_two_req_i(two_req), .rx2_holds_data_i(rx2),
        .tx2_buf_empty_i(tx2), .timer4_overflow_i(tmr4),
        .capcomp_event_i(cc_ev), .capcomp_pwm_i(cc_pwm),
        .peripheral_irq_o(irq_o));

    pife_src_model pife_src_model_inst (.clk_i(clk_i), .one_req_o(one_req),
        .two_req_o(two_req), .rx2_o(rx2), .tx2_o(tx2), .tmr4_o(tmr4),
        .cc_ev_o(cc_ev), .cc_pwm_o(cc_pwm));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        compares++;
        if (rdat !== exp)
        begin
            bad_count++;
            $display("[ERR] reg %h expected %h seen %h", a, exp, rdat);
        end
    endtask : chk_reg

    // The request line is looked at once its registered update has landed.
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk_i);
        compares++;
        if (irq_o !== exp)
        begin
            bad_count++;
            $display("[ERR] irq expected %b seen %b", exp, irq_o);
        end
    endtask : chk_irq

    // Classic cycle: hold everything until ack is sampled high, then release.
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr} <= {2'h3, w, a};
        wb_dat <= {24'h000000, d};
        // No timeout here; only the watchdog ends a wait that never sees the acknowledge.
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'h1);
        rdat = wb_dat_o;
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(a, 1'h0, 8'h00);
        chk_reg(a, {24'h000000, exp});
    endtask : rd

    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        tally_and_finish;
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (offs[i]) rd(offs[i], 8'h00);
        wb(PIFE_OFF_EN1, 1'h1, 8'hA5);
        wb(PIFE_OFF_EN2, 1'h1, 8'h5A);
        wb(PIFE_OFF_EN3, 1'h1, 8'hFF);
        wb(8'h20, 1'h1, 8'hFF);
        rd(PIFE_OFF_EN1, 8'hA5);
        rd(PIFE_OFF_EN2, 8'h5A);
        rd(PIFE_OFF_EN3, 8'h3F);
        rd(8'h20, 8'h00);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'hFF);
        rd(PIFE_OFF_FLAGS3, 8'h0F);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'h00);
        rd(PIFE_OFF_FLAGS3, 8'h00);
        pife_src_model_inst.levels(8'h00, 8'h00, 2'h3, 3'h0);
        rd(PIFE_OFF_FLAGS3, 8'h30);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'h00);
        rd(PIFE_OFF_FLAGS3, 8'h30);
        pife_src_model_inst.levels(8'h00, 8'h00, 2'h2, 3'h0);
        rd(PIFE_OFF_FLAGS3, 8'h20);
        pife_src_model_inst.levels(8'h00, 8'h00, 2'h0, 3'h0);
        for (int i = 0; i < 4; i++)
        begin
            pife_src_model_inst.pulse(i == 3, 3'(1 << i));
            repeat (6) @(posedge clk_i);
            rd(PIFE_OFF_FLAGS3, 8'(1 << i));
            wb(PIFE_OFF_FLAGS3, 1'h1, 8'h00);
            rd(PIFE_OFF_FLAGS3, 8'h00);
        end
        pife_src_model_inst.levels(8'h00, 8'h00, 2'h0, 3'h2);
        pife_src_model_inst.pulse(1'h0, 3'h2);
        rd(PIFE_OFF_FLAGS3, 8'h00);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'hFF);
        rd(PIFE_OFF_FLAGS3, 8'h0D);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'h00);
        rd(PIFE_OFF_FLAGS3, 8'h00);
        pife_src_model_inst.levels(8'h01, 8'h80, 2'h0, 3'h0);
        wb(PIFE_OFF_EN2, 1'h1, 8'h00);
        wb(PIFE_OFF_EN3, 1'h1, 8'h00);
        wb(PIFE_OFF_EN1, 1'h1, 8'h01);
        chk_irq(1'h0);
        wb(PIFE_OFF_GATE, 1'h1, 8'h01);
        chk_irq(1'h1);
        wb(PIFE_OFF_EN1, 1'h1, 8'hFE);
        chk_irq(1'h0);
        wb(PIFE_OFF_EN2, 1'h1, 8'h80);
        chk_irq(1'h1);
        wb(PIFE_OFF_EN2, 1'h1, 8'h00);
        pife_src_model_inst.pulse(1'h0, 3'h4);
        wb(PIFE_OFF_EN3, 1'h1, 8'h04);
        chk_irq(1'h1);
        wb(PIFE_OFF_FLAGS3, 1'h1, 8'h00);
        chk_irq(1'h0);
        wb(PIFE_OFF_EN1, 1'h1, 8'h01);
        wb(PIFE_OFF_GATE, 1'h1, 8'h00);
        chk_irq(1'h0);
        wb(PIFE_OFF_RCTL, 1'h1, 8'h80);
        chk_irq(1'h1);
        rd(PIFE_OFF_RCTL, 8'h80);
        tally_and_finish;
    end
endmodule : pife_top_tb

`default_nettype wire
